// file: design/ocp_output_clock_control_pair.sv
// Control registers and output paths for the third and fourth output clocks
//
// Operation
// - Third output bit 7 set powers its driver down; clear powers it up.
// - Fourth output bit 7 set powers its driver down; clear keeps it powered.
// - Bit 6 picks divider mode: 0 fractional, 1 integer.
// - Bit 5 picks divider reference: 0 first loop, 1 second loop.
// - Bit 4 set drives the inverted clock; clear passes it unchanged.
// - Source 00 routes the crystal straight to the output.
// - Source 01 routes the external reference input straight to the output.
// - Source 11 drives the output from its own output divider.
// - Fourth output bits 3:2 choose which source drives it.
module ocp_output_clock_control_pair
	import ocp_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic                  regSelect,
	input  wire logic                  regWrite,
	input  wire logic [ADDR_WIDTH-1:0] regAddr,
	input  wire logic [REG_WIDTH-1:0]  regWriteData,
	output logic      [REG_WIDTH-1:0]  regReadData,
	output logic                       regReadValid,
	input  wire logic                  crystalClock,
	input  wire logic                  referenceClock,
	input  wire logic                  thirdDividerClock,
	input  wire logic                  fourthDividerClock,
	output logic                       thirdOutputClock,
	output logic                       fourthOutputClock,
	output logic                       thirdOutputDriverEnable,
	output logic                       fourthOutputDriverEnable,
	output logic                       thirdDividerIntegerMode,
	output logic                       fourthDividerIntegerMode,
	output logic                       thirdDividerLoopSelect,
	output logic                       fourthDividerLoopSelect
);

	//--------------------------------------------------------------
	// Address decode
	//--------------------------------------------------------------
	logic [7:0] thirdOutputControl;
	logic [7:0] fourthOutputControl;
	logic       hitThird;
	logic       hitFourth;
	logic       writeThird;
	logic       writeFourth;
	logic       readAccess;
	logic [7:0] next_regReadData;

	assign hitThird    = regAddr == THIRD_OUTPUT_CONTROL;
	assign hitFourth   = regAddr == FOURTH_OUTPUT_CONTROL;
	assign writeThird  = regSelect && regWrite && hitThird;
	assign writeFourth = regSelect && regWrite && hitFourth;
	assign readAccess  = regSelect && !regWrite;

	assign next_regReadData = hitThird  ? thirdOutputControl :
	                          hitFourth ? fourthOutputControl :
	                                      UNMAPPED_READ;

	//--------------------------------------------------------------
	// Control registers
	//--------------------------------------------------------------
	ocp_ctrl_reg thirdReg
	(
		.clk         (clk),
		.rst_n       (rst_n),
		.writeEnable (writeThird),
		.writeData   (regWriteData),
		.value       (thirdOutputControl)
	);

	ocp_ctrl_reg fourthReg
	(
		.clk         (clk),
		.rst_n       (rst_n),
		.writeEnable (writeFourth),
		.writeData   (regWriteData),
		.value       (fourthOutputControl)
	);

	//--------------------------------------------------------------
	// Read port
	//--------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			regReadData  <= UNMAPPED_READ;
			regReadValid <= 1'b0;
		end
		else
		begin
			regReadValid <= readAccess;
			if (readAccess)
				regReadData <= next_regReadData;
		end
	end

	//--------------------------------------------------------------
	// Divider controls
	//--------------------------------------------------------------
	assign thirdDividerIntegerMode  = thirdOutputControl[INTEGER_MODE_BIT];
	assign fourthDividerIntegerMode = fourthOutputControl[INTEGER_MODE_BIT];
	assign thirdDividerLoopSelect   = thirdOutputControl[LOOP_SELECT_BIT];
	assign fourthDividerLoopSelect  = fourthOutputControl[LOOP_SELECT_BIT];

	//--------------------------------------------------------------
	// Output paths
	//--------------------------------------------------------------
	// Third output: power-down, polarity and source
	ocp_output_path thirdPath
	(
		.crystalClock   (crystalClock),
		.referenceClock (referenceClock),
		.dividerClock   (thirdDividerClock),
		.control        (thirdOutputControl),
		.outputClock    (thirdOutputClock),
		.driverEnable   (thirdOutputDriverEnable)
	);

	// Fourth output shares the same source encoding
	ocp_output_path fourthPath
	(
		.crystalClock   (crystalClock),
		.referenceClock (referenceClock),
		.dividerClock   (fourthDividerClock),
		.control        (fourthOutputControl),
		.outputClock    (fourthOutputClock),
		.driverEnable   (fourthOutputDriverEnable)
	);

	//--------------------------------------------------------------
	// Checks
	//--------------------------------------------------------------
	ocp_source_t thirdSource;
	ocp_source_t fourthSource;

	assign thirdSource  = ocpSourceOf(thirdOutputControl);
	assign fourthSource = ocpSourceOf(fourthOutputControl);

	a_third_power_down: assert property (
		@(posedge clk) disable iff (!rst_n)
		writeThird |=> (thirdOutputDriverEnable == !$past(regWriteData[POWER_DOWN_BIT]))
		               && (thirdOutputDriverEnable || !thirdOutputClock)
	) else $error("third driver enable does not follow power-down bit");

	a_fourth_power_down: assert property (
		@(posedge clk) disable iff (!rst_n)
		writeFourth ##1 fourthOutputControl[POWER_DOWN_BIT]
		|-> !fourthOutputDriverEnable && !fourthOutputClock
	) else $error("fourth output active while powered down");

	a_divider_mode_write: assert property (
		@(posedge clk) disable iff (!rst_n)
		writeThird |=> thirdDividerIntegerMode == $past(regWriteData[INTEGER_MODE_BIT])
	) else $error("third divider mode not taken from write");

	a_divider_mode_hold: assert property (
		@(posedge clk) disable iff (!rst_n)
		!writeFourth |=> $stable(fourthDividerIntegerMode)
	) else $error("fourth divider mode changed without a write");

	a_loop_select_write: assert property (
		@(posedge clk) disable iff (!rst_n)
		writeFourth |=> fourthDividerLoopSelect == $past(regWriteData[LOOP_SELECT_BIT])
		                && fourthDividerIntegerMode == $past(regWriteData[INTEGER_MODE_BIT])
	) else $error("fourth divider controls not taken from write");

	a_crystal_bypass: assert property (
		@(posedge clk) disable iff (!rst_n)
		(thirdSource == OCP_SRC_CRYSTAL && thirdOutputDriverEnable)
		|-> thirdOutputClock == (crystalClock ^ thirdOutputControl[INVERT_BIT])
	) else $error("third output not following crystal");

	a_reference_bypass: assert property (
		@(posedge clk) disable iff (!rst_n)
		(thirdSource == OCP_SRC_REFERENCE && thirdOutputDriverEnable)
		|-> thirdOutputClock == (referenceClock ^ thirdOutputControl[INVERT_BIT])
	) else $error("third output not following reference input");

	a_divider_source: assert property (
		@(posedge clk) disable iff (!rst_n)
		(thirdSource == OCP_SRC_DIVIDER && thirdOutputDriverEnable)
		|-> thirdOutputClock == (thirdDividerClock ^ thirdOutputControl[INVERT_BIT])
	) else $error("third output not following its divider");

	a_output_invert: assert property (
		@(posedge clk) disable iff (!rst_n)
		(fourthSource == OCP_SRC_DIVIDER && fourthOutputDriverEnable && fourthOutputControl[INVERT_BIT])
		|-> fourthOutputClock != fourthDividerClock
	) else $error("fourth output not inverted");

	a_fourth_source: assert property (
		@(posedge clk) disable iff (!rst_n)
		(fourthOutputDriverEnable && !fourthOutputControl[INVERT_BIT])
		|-> fourthOutputClock == ((fourthSource == OCP_SRC_CRYSTAL)   ? crystalClock :
		                          (fourthSource == OCP_SRC_REFERENCE) ? referenceClock :
		                          (fourthSource == OCP_SRC_DIVIDER)   ? fourthDividerClock : 1'b0)
	) else $error("fourth output source mismatch");

	a_read_back: assert property (
		@(posedge clk) disable iff (!rst_n)
		(readAccess && hitFourth) |=> regReadValid && regReadData == fourthOutputControl
	) else $error("fourth register read back wrong");

	//--------------------------------------------------------------
	// Hold, symmetry and read port checks
	//--------------------------------------------------------------

	a_third_mode_hold: assert property (
		@(posedge clk) disable iff (!rst_n)
		!writeThird |=> $stable(thirdDividerIntegerMode)
	) else $error("third divider mode changed without a write");

	a_third_loop_write: assert property (
		@(posedge clk) disable iff (!rst_n)
		writeThird |=> thirdDividerLoopSelect == $past(regWriteData[LOOP_SELECT_BIT])
	) else $error("third divider reference not taken from write");

	a_loop_select_hold: assert property (
		@(posedge clk) disable iff (!rst_n)
		(!writeThird && !writeFourth)
		|=> $stable(thirdDividerLoopSelect) && $stable(fourthDividerLoopSelect)
	) else $error("divider reference changed without a write");

	a_fourth_driver_write: assert property (
		@(posedge clk) disable iff (!rst_n)
		writeFourth |=> fourthOutputDriverEnable == !$past(regWriteData[POWER_DOWN_BIT])
	) else $error("fourth driver enable does not follow power-down bit");

	a_third_driver_hold: assert property (
		@(posedge clk) disable iff (!rst_n)
		!writeThird |=> $stable(thirdOutputDriverEnable)
	) else $error("third driver enable changed without a write");

	a_fourth_driver_hold: assert property (
		@(posedge clk) disable iff (!rst_n)
		!writeFourth |=> $stable(fourthOutputDriverEnable)
	) else $error("fourth driver enable changed without a write");

	a_third_invert: assert property (
		@(posedge clk) disable iff (!rst_n)
		(thirdSource == OCP_SRC_DIVIDER && thirdOutputDriverEnable && thirdOutputControl[INVERT_BIT])
		|-> thirdOutputClock != thirdDividerClock
	) else $error("third output not inverted");

	a_fourth_crystal: assert property (
		@(posedge clk) disable iff (!rst_n)
		(fourthSource == OCP_SRC_CRYSTAL && fourthOutputDriverEnable)
		|-> fourthOutputClock == (crystalClock ^ fourthOutputControl[INVERT_BIT])
	) else $error("fourth output not following crystal");

	a_fourth_reference: assert property (
		@(posedge clk) disable iff (!rst_n)
		(fourthSource == OCP_SRC_REFERENCE && fourthOutputDriverEnable)
		|-> fourthOutputClock == (referenceClock ^ fourthOutputControl[INVERT_BIT])
	) else $error("fourth output not following reference input");

	a_fourth_divider: assert property (
		@(posedge clk) disable iff (!rst_n)
		(fourthSource == OCP_SRC_DIVIDER && fourthOutputDriverEnable)
		|-> fourthOutputClock == (fourthDividerClock ^ fourthOutputControl[INVERT_BIT])
	) else $error("fourth output not following its divider");

	a_reserved_third: assert property (
		@(posedge clk) disable iff (!rst_n)
		writeThird |=> thirdOutputControl[SOURCE_LSB-1:0] == $past(regWriteData[SOURCE_LSB-1:0])
	) else $error("third reserved bits not stored");

	a_reserved_fourth: assert property (
		@(posedge clk) disable iff (!rst_n)
		writeFourth |=> fourthOutputControl[SOURCE_LSB-1:0] == $past(regWriteData[SOURCE_LSB-1:0])
	) else $error("fourth reserved bits not stored");

	a_fourth_source_hold: assert property (
		@(posedge clk) disable iff (!rst_n)
		!writeFourth |=> $stable(fourthSource)
	) else $error("fourth source changed without a write");

	a_third_source_hold: assert property (
		@(posedge clk) disable iff (!rst_n)
		!writeThird |=> $stable(thirdSource)
	) else $error("third source changed without a write");

	a_read_valid: assert property (
		@(posedge clk) disable iff (!rst_n)
		readAccess |=> regReadValid
	) else $error("read not answered in the next cycle");

	a_read_valid_low: assert property (
		@(posedge clk) disable iff (!rst_n)
		!readAccess |=> !regReadValid
	) else $error("read valid raised without a read");

	a_read_third: assert property (
		@(posedge clk) disable iff (!rst_n)
		(readAccess && hitThird) |=> regReadValid && regReadData == thirdOutputControl
	) else $error("third register read back wrong");

	a_read_data_hold: assert property (
		@(posedge clk) disable iff (!rst_n)
		!readAccess |=> $stable(regReadData)
	) else $error("read data changed without a read");

endmodule

// file: design/ocp_pkg.sv
// Constants and helpers shared by the output clock control pair
package ocp_pkg;

	//--------------------------------------------------------------
	// Register map and widths
	//--------------------------------------------------------------
	localparam int        REG_WIDTH              = 8;
	localparam int        ADDR_WIDTH             = 8;
	localparam logic [7:0] THIRD_OUTPUT_CONTROL  = 8'h12;
	localparam logic [7:0] FOURTH_OUTPUT_CONTROL = 8'h13;
	localparam logic [7:0] CONTROL_RESET         = 8'h00;
	localparam logic [7:0] UNMAPPED_READ         = 8'h00;

	//--------------------------------------------------------------
	// Field positions
	//--------------------------------------------------------------
	localparam int POWER_DOWN_BIT   = 7;
	localparam int INTEGER_MODE_BIT = 6;
	localparam int LOOP_SELECT_BIT  = 5;
	localparam int INVERT_BIT       = 4;
	localparam int SOURCE_MSB       = 3;
	localparam int SOURCE_LSB       = 2;

	//--------------------------------------------------------------
	// Output source encoding
	//--------------------------------------------------------------
	typedef enum logic [1:0]
	{
		OCP_SRC_CRYSTAL   = 2'h0,
		OCP_SRC_REFERENCE = 2'h1,
		OCP_SRC_RESERVED  = 2'h2,
		OCP_SRC_DIVIDER   = 2'h3
	} ocp_source_t;

	function automatic ocp_source_t ocpSourceOf(input logic [7:0] control);
		ocpSourceOf = ocp_source_t'(control[SOURCE_MSB:SOURCE_LSB]);
	endfunction

endpackage

// file: design/ocp_ctrl_reg.sv
// One 8-bit read/write output control register
module ocp_ctrl_reg
	import ocp_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       writeEnable,
	input  wire logic [7:0] writeData,
	output logic      [7:0] value
);

	// Reserved bits are stored as written so software can preserve them
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			value <= CONTROL_RESET;
		else if (writeEnable)
			value <= writeData;
	end

endmodule

// file: design/ocp_output_path.sv
// Source select, inversion and driver power-down for one output clock
module ocp_output_path
	import ocp_pkg::*;
(
	input  wire logic       crystalClock,
	input  wire logic       referenceClock,
	input  wire logic       dividerClock,
	input  wire logic [7:0] control,
	output logic            outputClock,
	output logic            driverEnable
);

	ocp_source_t source;
	logic        selectedClock;
	logic        polarityClock;
	logic        powerDown;

	assign source = ocpSourceOf(control);
	assign powerDown = control[POWER_DOWN_BIT];

	// Reserved source code gives a quiet output, low unless bit 4 inverts it high
	always_comb
	begin
		unique case (source)
			OCP_SRC_CRYSTAL:   selectedClock = crystalClock;
			OCP_SRC_REFERENCE: selectedClock = referenceClock;
			OCP_SRC_RESERVED:  selectedClock = 1'b0;
			OCP_SRC_DIVIDER:   selectedClock = dividerClock;
		endcase
	end

	assign polarityClock = selectedClock ^ control[INVERT_BIT];
	assign driverEnable  = !powerDown;
	assign outputClock   = polarityClock & !powerDown;

endmodule

// file: testbench/ocp_clock_receiver.sv
// Receiver model for one generated output clock
module ocp_clock_receiver
(
	input  wire logic outputClock,
	input  wire logic driverEnable,
	output logic      seenClock
);
	timeunit 1ns;
	timeprecision 100ps;
	logic lastLevel = 1'h0;
	// Released line shows the inverse of the last driven level
	assign seenClock = driverEnable ? outputClock : ~lastLevel;
	always @(outputClock or driverEnable)
		if (driverEnable)
			lastLevel = outputClock;
endmodule

// file: testbench/ocp_output_clock_control_pair_tb_top.sv
// Self-checking bench for the output clock control pair
module ocp_output_clock_control_pair_tb_top
	import ocp_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic       clk, rst_n, regSelect, regWrite, regReadValid;
	logic       crystalClock, referenceClock, thirdDividerClock, fourthDividerClock;
	logic [7:0] regAddr, regWriteData, regReadData, v;
	logic       thirdOutputClock, fourthOutputClock, thirdOutputDriverEnable, fourthOutputDriverEnable;
	logic       thirdDividerIntegerMode, fourthDividerIntegerMode, thirdDividerLoopSelect, fourthDividerLoopSelect;
	logic       thirdSeen, fourthSeen;
	logic [7:0] expQ[$];
	logic [7:0] shadow[2];
	int         n_fail, total_checks;

	ocp_output_clock_control_pair uut (.clk(clk), .rst_n(rst_n), .regSelect(regSelect), .regWrite(regWrite),
		.regAddr(regAddr), .regWriteData(regWriteData), .regReadData(regReadData), .regReadValid(regReadValid),
		.crystalClock(crystalClock), .referenceClock(referenceClock), .thirdDividerClock(thirdDividerClock),
		.fourthDividerClock(fourthDividerClock), .thirdOutputClock(thirdOutputClock),
		.fourthOutputClock(fourthOutputClock), .thirdOutputDriverEnable(thirdOutputDriverEnable),
		.fourthOutputDriverEnable(fourthOutputDriverEnable), .thirdDividerIntegerMode(thirdDividerIntegerMode),
		.fourthDividerIntegerMode(fourthDividerIntegerMode), .thirdDividerLoopSelect(thirdDividerLoopSelect),
		.fourthDividerLoopSelect(fourthDividerLoopSelect));
	ocp_clock_receiver rxThird (.outputClock(thirdOutputClock), .driverEnable(thirdOutputDriverEnable),
		.seenClock(thirdSeen));
	ocp_clock_receiver rxFourth (.outputClock(fourthOutputClock), .driverEnable(fourthOutputDriverEnable),
		.seenClock(fourthSeen));

	always #2.5 clk = ~clk;

	//----------------------------------------------------------
	// Compare, bus and probe tasks
	//----------------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish;
		$display("checks=%0d mismatches=%0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Leaves the strobe high so accesses can run back to back
	task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
		regSelect = 1'h1;
		regWrite = wr;
		regAddr = a;
		regWriteData = d;
		if (!wr)
			expQ.push_back(d);
		else if (a == THIRD_OUTPUT_CONTROL || a == FOURTH_OUTPUT_CONTROL)
			shadow[a[0]] = d;
		@(posedge clk);
		#1;
	endtask

	task automatic idle;
		regSelect = 1'h0;
		@(posedge clk);
		#1;
		for (int k = 0; k < 20 && expQ.size() > 0; k++)
		begin
			@(posedge clk);
			#1;
		end
		if (expQ.size() > 0)
		begin
			check(8'(expQ.size()), 8'h00);
			tally_and_finish;
		end
	endtask

	function automatic logic [7:0] expOut(input logic [7:0] c, input logic dclk);
		logic [3:0] src;
		logic       o;
		src = {dclk, 1'h0, referenceClock, crystalClock};
		o = c[7] ? 1'h0 : src[c[3:2]] ^ c[4];
		expOut = {3'h0, ~c[7], c[6], c[5], o, o};
	endfunction

	// Entered and left just after a rising edge
	task automatic probe(input int n);
		logic [7:0] seenThird;
		logic [7:0] seenFourth;
		repeat (n)
		begin
			{crystalClock, referenceClock, thirdDividerClock, fourthDividerClock} = 4'($urandom);
			#1;
			seenThird = {3'h0, thirdOutputDriverEnable, thirdDividerIntegerMode, thirdDividerLoopSelect,
				thirdOutputClock, shadow[0][7] ? 1'h0 : thirdSeen};
			seenFourth = {3'h0, fourthOutputDriverEnable, fourthDividerIntegerMode, fourthDividerLoopSelect,
				fourthOutputClock, shadow[1][7] ? 1'h0 : fourthSeen};
			check(seenThird, expOut(shadow[0], thirdDividerClock));
			check(seenFourth, expOut(shadow[1], fourthDividerClock));
			@(posedge clk);
			#1;
		end
	endtask

	// Read results are taken off the queue as they appear
	always @(negedge clk)
		if (regReadValid === 1'h1)
		begin
			if (expQ.size() == 0)
				check(8'(expQ.size()), 8'h01);
			else
				check(regReadData, expQ.pop_front());
		end

	//----------------------------------------------------------
	// Main sequence
	//----------------------------------------------------------
	initial
	begin
		clk = 1'h0;
		rst_n = 1'h0;
		{regSelect, regWrite, regAddr, regWriteData} = 18'h0;
		{crystalClock, referenceClock, thirdDividerClock, fourthDividerClock} = 4'h0;
		n_fail = 0;
		total_checks = 0;
		shadow = '{CONTROL_RESET, CONTROL_RESET};
		void'($urandom(32'h6CF6ECE5));
		repeat (10) @(posedge clk);
		#1;
		rst_n = 1'h1;
		probe(4);
		access(1'h0, THIRD_OUTPUT_CONTROL, CONTROL_RESET);
		access(1'h0, FOURTH_OUTPUT_CONTROL, CONTROL_RESET);
		access(1'h0, 8'h14, UNMAPPED_READ);
		idle;
		for (int i = 0; i < 48; i++)
		begin
			// Reserved source code 10 is never programmed and bits 1:0 are written as zero
			v = 8'($urandom);
			if (i < 8)
				v[3:2] = 2'(i >> 1);
			if (v[3:2] == 2'h2)
				v[3:2] = 2'h3;
			v[1:0] = 2'h0;
			access(1'h1, {7'h09, i[0]}, v);
			if (i % 4 == 3)
			begin
				access(1'h0, THIRD_OUTPUT_CONTROL, shadow[0]);
				access(1'h0, FOURTH_OUTPUT_CONTROL, shadow[1]);
			end
			idle;
			probe(6);
		end
		access(1'h1, 8'h11, 8'hF0);
		access(1'h1, 8'h14, 8'hF0);
		access(1'h0, THIRD_OUTPUT_CONTROL, shadow[0]);
		access(1'h0, FOURTH_OUTPUT_CONTROL, shadow[1]);
		idle;
		rst_n = 1'h0;
		shadow = '{CONTROL_RESET, CONTROL_RESET};
		probe(3);
		@(posedge clk);
		#1;
		rst_n = 1'h1;
		access(1'h0, FOURTH_OUTPUT_CONTROL, CONTROL_RESET);
		idle;
		probe(3);
		tally_and_finish;
	end
endmodule
